/* File: logic/cis_input_select.sv */
/*
  Comparator 1 input select register on the special-function-register bus,
  with its two select fields and one-hot switch enables.
  Assumes the core drives page, address, write and read strobes on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cis_input_select
  import cis_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output cis_sel_t sel,
  output cis_mux_t mux
);
  logic [7:0] select_reg;
  logic [7:0] rdata_reg;
  logic hit;

  // address decode
  assign hit = (sfr_page == CIS_SFR_PAGE) && (sfr_addr == CIS_SFR_ADDR);
  assign sfr_hit = hit;

  // select register; firmware writes whole byte
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      select_reg <= CIS_RESET_VAL;
    end else if (sfr_wr && hit) begin
      select_reg <= sfr_wdata;
    end
  end

  // read data registered; other addresses read zero so the core can OR buses
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd && hit) begin
      rdata_reg <= select_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign sfr_rdata = rdata_reg;

  // fields straight to the analog multiplexers; one driver for the whole struct
  assign sel = '{
    negative_input_code: select_reg[CIS_NEG_HI:CIS_NEG_LO],
    positive_input_code: select_reg[CIS_POS_HI:CIS_POS_LO]
  };

  // reserved codes open all switches of their own multiplexer rather than guess a source
  cis_mux_decode u_decode (
    .sys_clk(sys_clk),
    .srst(srst),
    .sel(sel),
    .mux(mux)
  );

  // assertions
  property p_write_takes;
    @(posedge sys_clk) disable iff (srst)
      (sfr_wr && hit) |=> (select_reg == $past(sfr_wdata));
  endproperty
  a_write_takes: assert property (p_write_takes)
    else $error("select write not stored");

  property p_read_back;
    @(posedge sys_clk) disable iff (srst)
      (sfr_rd && hit && !sfr_wr) |=> (sfr_rdata == select_reg);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data differs from register");

  property p_no_stray_write;
    @(posedge sys_clk) disable iff (srst)
      (sfr_wr && !hit) |=> $stable(select_reg);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write)
    else $error("other address changed register");

  property p_neg_pin;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == CIS_NEG_P2_3) |=>
        (mux.neg_onehot == 16'h0200 && mux.neg_defined);
  endproperty
  a_neg_pin: assert property (p_neg_pin)
    else $error("negative pin code not decoded");

  property p_neg_ground;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == CIS_NEG_GROUND) |=>
        (mux.neg_onehot == 16'h8000 && mux.neg_defined);
  endproperty
  a_neg_ground: assert property (p_neg_ground)
    else $error("ground not selected");

  property p_pos_pin;
    @(posedge sys_clk) disable iff (srst)
      (sel.positive_input_code == CIS_POS_P0_6) |=> (mux.pos_onehot == 16'h0008);
  endproperty
  a_pos_pin: assert property (p_pos_pin)
    else $error("positive pin code not decoded");

  property p_pos_rail;
    @(posedge sys_clk) disable iff (srst)
      (sel.positive_input_code == CIS_POS_CONV_RAIL) |=>
        (mux.pos_onehot == 16'h8000 && mux.pos_defined);
  endproperty
  a_pos_rail: assert property (p_pos_rail)
    else $error("converter rail not selected");

  property p_reset_ones;
    @(posedge sys_clk) srst |=> (select_reg == CIS_RESET_VAL);
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("reset value not all ones");

  property p_reserved_open;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == 4'ha) |=>
        (mux.neg_onehot == 16'h0000 && !mux.neg_defined);
  endproperty
  a_reserved_open: assert property (p_reserved_open)
    else $error("reserved code connected a source");

  // positive field has its own reserved set
  property p_pos_reserved_open;
    @(posedge sys_clk) disable iff (srst)
      (sel.positive_input_code == 4'h4) |=>
        (mux.pos_onehot == 16'h0000 && !mux.pos_defined);
  endproperty
  a_pos_reserved_open: assert property (p_pos_reserved_open)
    else $error("reserved positive code connected a source");

  // a miss must not leak data onto the shared read bus
  property p_read_miss_zero;
    @(posedge sys_clk) disable iff (srst)
      (sfr_rd && !hit) |=> (sfr_rdata == 8'h00);
  endproperty
  a_read_miss_zero: assert property (p_read_miss_zero)
    else $error("missed read drove data");

  // read data stands for one cycle only
  property p_read_idle_zero;
    @(posedge sys_clk) disable iff (srst)
      !sfr_rd |=> (sfr_rdata == 8'h00);
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero)
    else $error("read data held without strobe");

  // read in the write cycle returns the value before the write
  property p_read_old_value;
    @(posedge sys_clk) disable iff (srst)
      (sfr_rd && sfr_wr && hit) |=> (sfr_rdata == $past(select_reg));
  endproperty
  a_read_old_value: assert property (p_read_old_value)
    else $error("read during write not old value");

  property p_neg_low_pin;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == CIS_NEG_P0_1) |=>
        (mux.neg_onehot == 16'h0001 && mux.neg_defined);
  endproperty
  a_neg_low_pin: assert property (p_neg_low_pin)
    else $error("first negative pin not decoded");

  property p_neg_touch;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == CIS_NEG_TOUCH) |=>
        (mux.neg_onehot == 16'h1000 && mux.neg_defined);
  endproperty
  a_neg_touch: assert property (p_neg_touch)
    else $error("negative touch level not selected");

  property p_neg_half_bat;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == CIS_NEG_HALF_BAT) |=>
        (mux.neg_onehot == 16'h2000 && mux.neg_defined);
  endproperty
  a_neg_half_bat: assert property (p_neg_half_bat)
    else $error("negative half battery not selected");

  property p_neg_supply;
    @(posedge sys_clk) disable iff (srst)
      (sel.negative_input_code == CIS_NEG_DIG_SUPPLY) |=>
        (mux.neg_onehot == 16'h4000 && mux.neg_defined);
  endproperty
  a_neg_supply: assert property (p_neg_supply)
    else $error("digital supply not selected");

  property p_pos_low_pin;
    @(posedge sys_clk) disable iff (srst)
      (sel.positive_input_code == CIS_POS_P0_0) |=>
        (mux.pos_onehot == 16'h0001 && mux.pos_defined);
  endproperty
  a_pos_low_pin: assert property (p_pos_low_pin)
    else $error("first positive pin not decoded");

  property p_pos_half_bat;
    @(posedge sys_clk) disable iff (srst)
      (sel.positive_input_code == CIS_POS_HALF_BAT) |=>
        (mux.pos_onehot == 16'h2000 && mux.pos_defined);
  endproperty
  a_pos_half_bat: assert property (p_pos_half_bat)
    else $error("positive half battery not selected");

  property p_pos_battery;
    @(posedge sys_clk) disable iff (srst)
      (sel.positive_input_code == CIS_POS_BAT_SUPPLY) |=>
        (mux.pos_onehot == 16'h4000 && mux.pos_defined);
  endproperty
  a_pos_battery: assert property (p_pos_battery)
    else $error("battery supply not selected");

  // switch enables come out of reset on the all-ones codes
  property p_reset_mux;
    @(posedge sys_clk) srst |=>
      (mux.neg_onehot == 16'h8000 && mux.pos_onehot == 16'h8000 &&
       mux.neg_defined && mux.pos_defined);
  endproperty
  a_reset_mux: assert property (p_reset_mux)
    else $error("switch enables wrong after reset");

  c_write: cover property (@(posedge sys_clk) sfr_wr && hit);
  c_read: cover property (@(posedge sys_clk) sfr_rd && hit);
  c_touch: cover property (@(posedge sys_clk) sel.positive_input_code == CIS_POS_TOUCH);
  c_reserved: cover property (@(posedge sys_clk) !mux.pos_defined);
endmodule : cis_input_select
`default_nettype wire

/* File: include/cis_pkg.sv */
/*
  Package for the comparator input select register: address, reset value,
  field positions and select codes for both analog multiplexers.
  Assumes a special-function-register bus with page, address, strobes.
*/
`default_nettype none
package cis_pkg;
  localparam logic [3:0] CIS_SFR_PAGE = 4'h0;
  localparam logic [7:0] CIS_SFR_ADDR = 8'h9e;
  localparam logic [7:0] CIS_RESET_VAL = 8'hff;
  localparam int CIS_NEG_HI = 7;
  localparam int CIS_NEG_LO = 4;
  localparam int CIS_POS_HI = 3;
  localparam int CIS_POS_LO = 0;

  // negative multiplexer sources
  typedef enum logic [3:0] {
    CIS_NEG_P0_1 = 4'h0,
    CIS_NEG_P0_3 = 4'h1,
    CIS_NEG_P0_5 = 4'h2,
    CIS_NEG_P1_5 = 4'h6,
    CIS_NEG_P1_7 = 4'h7,
    CIS_NEG_P2_1 = 4'h8,
    CIS_NEG_P2_3 = 4'h9,
    CIS_NEG_TOUCH = 4'hc,
    CIS_NEG_HALF_BAT = 4'hd,
    CIS_NEG_DIG_SUPPLY = 4'he,
    CIS_NEG_GROUND = 4'hf
  } cis_neg_code_t;

  // positive multiplexer sources
  typedef enum logic [3:0] {
    CIS_POS_P0_0 = 4'h0,
    CIS_POS_P0_2 = 4'h1,
    CIS_POS_P0_4 = 4'h2,
    CIS_POS_P0_6 = 4'h3,
    CIS_POS_P1_4 = 4'h6,
    CIS_POS_P1_6 = 4'h7,
    CIS_POS_P2_0 = 4'h8,
    CIS_POS_P2_2 = 4'h9,
    CIS_POS_TOUCH = 4'hc,
    CIS_POS_HALF_BAT = 4'hd,
    CIS_POS_BAT_SUPPLY = 4'he,
    CIS_POS_CONV_RAIL = 4'hf
  } cis_pos_code_t;

  // select codes travelling together to the analog side
  typedef struct packed {
    logic [3:0] negative_input_code;
    logic [3:0] positive_input_code;
  } cis_sel_t;

  // one-hot view of the chosen sources, for the analog switch drivers
  typedef struct packed {
    logic [15:0] neg_onehot;
    logic [15:0] pos_onehot;
    logic neg_defined;
    logic pos_defined;
  } cis_mux_t;
endpackage : cis_pkg
`default_nettype wire

/* File: logic/cis_mux_decode.sv */
/*
  Decoder from the two select codes to one-hot switch enables.
  Assumes the codes come from a register on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cis_mux_decode
  import cis_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire cis_sel_t sel,
  output cis_mux_t mux
);
  // a reserved code opens every switch of its own multiplexer; no source is defined there
  function automatic logic neg_ok(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'ha, 4'hb: neg_ok = 1'b0;
      default: neg_ok = 1'b1;
    endcase
  endfunction : neg_ok

  function automatic logic pos_ok(input logic [3:0] c);
    case (c)
      4'h4, 4'h5, 4'ha, 4'hb: pos_ok = 1'b0;
      default: pos_ok = 1'b1;
    endcase
  endfunction : pos_ok

  // registered so switch drivers never see decode glitches
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mux.neg_onehot <= 16'h8000;
      mux.pos_onehot <= 16'h8000;
      mux.neg_defined <= 1'b1;
      mux.pos_defined <= 1'b1;
    end else begin
      mux.neg_defined <= neg_ok(sel.negative_input_code);
      mux.pos_defined <= pos_ok(sel.positive_input_code);
      mux.neg_onehot <= neg_ok(sel.negative_input_code) ?
                        (16'h0001 << sel.negative_input_code) : 16'h0000;
      mux.pos_onehot <= pos_ok(sel.positive_input_code) ?
                        (16'h0001 << sel.positive_input_code) : 16'h0000;
    end
  end
endmodule : cis_mux_decode
`default_nettype wire

/* File: test/cis_input_select_tb_top.sv */
/*
  self-checking bench for the comparator input select register: all code pairs,
  misses, read-during-write and a second reset.
  assumes cis_pkg is compiled first; bench alone drives the register bus.
*/
`timescale 1ns/1ns
`default_nettype none
module cis_input_select_tb_top
  import cis_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  cis_sel_t sel;
  cis_mux_t mux;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] v, rd_v;

  cis_input_select u_dut (.sys_clk(sys_clk), .srst(srst), .sfr_page(sfr_page),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sel(sel), .mux(mux));

  // 40 ns period
  initial forever #20 sys_clk = ~sys_clk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // reserved codes leave both one-hot and defined low
  function automatic logic [33:0] exp_mux(input logic [7:0] r);
    logic nd, pd;
    nd = !(r[7:4] inside {4'h3, 4'h4, 4'h5, 4'ha, 4'hb});
    pd = !(r[3:0] inside {4'h4, 4'h5, 4'ha, 4'hb});
    return {nd ? 16'h1 << r[7:4] : 16'h0, pd ? 16'h1 << r[3:0] : 16'h0, nd, pd};
  endfunction : exp_mux

  // one write strobe, taken at the second edge
  task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  // read data stands one cycle only, then must drop to zero
  task automatic rd(input logic [3:0] pg, input logic [7:0] ad, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(negedge sys_clk);
    d = sfr_rdata;
    @(negedge sys_clk);
    check(sfr_rdata, 8'h00);
  endtask : rd

  // hang guard: the sequence needs roughly 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'hf6cf));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    check(sel, 8'hff);
    check(mux, exp_mux(8'hff));
    rd(4'h0, 8'h9e, rd_v);
    check(rd_v, 8'hff);
    // every code pair, reserved ones included
    for (int i = 0; i < 256; i++) begin
      v = i[7:0];
      wr(4'h0, 8'h9e, v);
      @(negedge sys_clk);
      check(sel, v);
      check(sfr_hit, 1'b1);
      @(negedge sys_clk);
      check(mux, exp_mux(v));
      rd(4'h0, 8'h9e, rd_v);
      check(rd_v, v);
    end
    // random misses must not disturb the register or answer a read
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      sfr_page <= 4'($urandom);
      sfr_addr <= 8'($urandom);
      @(posedge sys_clk);
      if (sfr_page == 4'h0 && sfr_addr == 8'h9e) sfr_addr <= 8'h9d;
      @(negedge sys_clk);
      check(sfr_hit, 1'b0);
      wr(sfr_page, sfr_addr, 8'($urandom));
      rd(sfr_page, sfr_addr, rd_v);
      check(rd_v, 8'h00);
      check(sel, v);
      v = 8'($urandom);
      wr(4'h0, 8'h9e, v);
      rd(4'h0, 8'h9e, rd_v);
      check(rd_v, v);
    end
    // read in the write cycle sees the old value
    @(posedge sys_clk);
    sfr_wdata <= ~v;
    sfr_wr <= 1'b1;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    @(negedge sys_clk);
    check(sfr_rdata, v);
    check(sel, 8'(~v));
    // second reset in mid-run
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    check(sel, 8'hff);
    check(mux, exp_mux(8'hff));
    give_verdict();
  end
endmodule : cis_input_select_tb_top
`default_nettype wire
